// ---- hw/phy_expanded_ram_access.sv ----
`timescale 1ns/10ps
`default_nettype none

module phy_expanded_ram_access #(
    parameter logic [7:0] ROM_REV_HI = 8'hA5,   // Arbitrary value
    parameter logic [7:0] ROM_REV_LO = 8'h5A    // Arbitrary value
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic             writeReady,
    output logic [15:0]      regRdData,
    output logic             regRdValid,
    input  wire logic        linkUp,
    input  wire logic [1:0]  linkSpeed,
    input  wire logic        fullDuplex,
    input  wire logic [7:0]  eepromByte,
    input  wire logic        eepromByteValid,
    input  wire logic        eepromLoadDone,
    output logic             powerDown,
    output logic             asymPauseAdvert,
    output logic             execStart,
    output logic [15:0]      execAddr,
    output logic             codeAttention,
    output logic             ledSpeed10,
    output logic             ledSpeed100,
    output logic             ledSpeed1000
);

    typedef enum logic [1:0] {
        DRAIN_IDLE = 2'b00,
        DRAIN_HIGH = 2'b01
    } drain_state_e;

    logic [7:0]                  ram [phy_ram_pkg::RAM_BYTES];
    logic [15:0]                 control;
    logic [15:0]                 accessMode;
    logic [15:0]                 pointer;
    logic                        linkLatch;
    logic [7:0]                  checksumSum;
    logic [7:0]                  checksumCalc;
    logic [7:0]                  heldHigh;
    logic                        readPending;
    drain_state_e                drainState;

    phy_ram_pkg::write_entry_s   pushEntry;
    phy_ram_pkg::write_entry_s   popEntry;
    logic                        pushValid;
    logic                        fifoInReady;
    logic                        popValid;
    logic                        popReady;
    logic [phy_ram_pkg::WRITE_ENTRY_WIDTH-1:0] popBits;

    logic                        ramWrite;
    logic [15:0]                 ramWrAddr;
    logic [7:0]                  ramWrData;
    logic                        dataReadNow;
    logic                        wrAccepted;
    logic [7:0]                  readByte;

    function automatic logic inRam(input logic [15:0] addr);
        inRam = (addr >= phy_ram_pkg::RAM_BASE_ADDR) &&
                ({1'b0, addr} < ({1'b0, phy_ram_pkg::RAM_BASE_ADDR} +
                                 17'(phy_ram_pkg::RAM_BYTES)));
    endfunction

    function automatic logic [phy_ram_pkg::RAM_INDEX_WIDTH-1:0] ramIndex(
        input logic [15:0] addr);
        logic [15:0] offset;
        offset = addr - phy_ram_pkg::RAM_BASE_ADDR;
        ramIndex = offset[phy_ram_pkg::RAM_INDEX_WIDTH-1:0];
    endfunction

    // Writes are refused while the buffer is full
    assign wrAccepted = regWrite && writeReady;

    // Pointer and data writes share one buffer so their order is kept
    always_comb begin
        pushEntry.kind  = phy_ram_pkg::ENTRY_POINTER;
        pushEntry.value = regWrData;
        pushValid       = 1'b0;
        if (wrAccepted && regAddr == phy_ram_pkg::REG_EXPANDED_RAM_POINTER) begin
            pushValid = 1'b1;
        end else if (wrAccepted && regAddr == phy_ram_pkg::REG_EXPANDED_RAM_DATA) begin
            if (accessMode == phy_ram_pkg::MODE_BYTE_ACCESS) begin
                pushEntry.kind = phy_ram_pkg::ENTRY_BYTE;
                pushValid      = 1'b1;
            end else if (accessMode == phy_ram_pkg::MODE_WORD_ACCESS) begin
                pushEntry.kind = phy_ram_pkg::ENTRY_WORD;
                pushValid      = 1'b1;
            end
        end
    end

    write_fifo #(
        .WIDTH(phy_ram_pkg::WRITE_ENTRY_WIDTH),
        .DEPTH(phy_ram_pkg::WRITE_FIFO_DEPTH)
    ) u_write_fifo (
        .clock   (clock),
        .srst    (srst),
        .inData  (pushEntry),
        .inValid (pushValid),
        .inReady (fifoInReady),
        .outData (popBits),
        .outValid(popValid),
        .outReady(popReady)
    );

    assign popEntry = phy_ram_pkg::write_entry_s'(popBits);
    assign popReady = (drainState == DRAIN_IDLE);

    // Byte stores produced by the drain engine
    always_comb begin
        ramWrite  = 1'b0;
        ramWrAddr = pointer;
        ramWrData = popEntry.value[7:0];
        unique case (drainState)
            DRAIN_IDLE: begin
                ramWrite = popValid && (popEntry.kind != phy_ram_pkg::ENTRY_POINTER);
            end
            DRAIN_HIGH: begin
                // high byte goes to the next location
                ramWrite  = 1'b1;
                ramWrData = heldHigh;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            drainState <= DRAIN_IDLE;
            heldHigh   <= 8'h00;
        end else begin
            unique case (drainState)
                DRAIN_IDLE: begin
                    // word splits into two byte writes
                    if (popValid && popEntry.kind == phy_ram_pkg::ENTRY_WORD) begin
                        heldHigh   <= popEntry.value[15:8];
                        drainState <= DRAIN_HIGH;
                    end
                end
                DRAIN_HIGH: begin
                    drainState <= DRAIN_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (ramWrite && inRam(ramWrAddr)) begin
            ram[ramIndex(ramWrAddr)] <= ramWrData;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            asymPauseAdvert <= 1'b0;
        end else if (ramWrite && ramWrAddr == phy_ram_pkg::PAUSE_ADVERT_ADDR) begin
            asymPauseAdvert <= (ramWrData == phy_ram_pkg::PAUSE_ADVERT_VALUE);
        end
    end

    // Data reads wait until buffered writes have landed
    assign dataReadNow = readPending && !popValid && drainState == DRAIN_IDLE;

    always_ff @(posedge clock) begin
        if (srst) begin
            readPending <= 1'b0;
        end else if (dataReadNow) begin
            readPending <= 1'b0;
        end else if (regRead && regAddr == phy_ram_pkg::REG_EXPANDED_RAM_DATA) begin
            readPending <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pointer <= phy_ram_pkg::POINTER_RESET;
        end else if (drainState == DRAIN_IDLE && popValid &&
                     popEntry.kind == phy_ram_pkg::ENTRY_POINTER) begin
            pointer <= popEntry.value;
        // advance after each internal byte write
        end else if (ramWrite) begin
            pointer <= pointer + 16'h0001;
        end else if (dataReadNow) begin
            pointer <= pointer + 16'h0001;
        end
    end

    // Byte seen through the data register at the pointer
    always_comb begin
        readByte = 8'h00;
        if (pointer == phy_ram_pkg::ROM_REV_HI_ADDR) begin
            readByte = ROM_REV_HI;
        end else if (pointer == phy_ram_pkg::ROM_REV_LO_ADDR) begin
            readByte = ROM_REV_LO;
        // computed checksum replaces the stored byte
        end else if (pointer == phy_ram_pkg::CHECKSUM_CALC_ADDR) begin
            readByte = checksumCalc;
        // firmware revision and declared checksum come from RAM
        end else if (inRam(pointer)) begin
            readByte = ram[ramIndex(pointer)];
        end
    end

    // sum over the serial EEPROM load
    always_ff @(posedge clock) begin
        if (srst) begin
            checksumSum  <= 8'h00;
            checksumCalc <= 8'h00;
        end else if (eepromLoadDone) begin
            checksumCalc <= checksumSum;
            checksumSum  <= 8'h00;
        end else if (eepromByteValid) begin
            checksumSum <= checksumSum + eepromByte;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            control   <= phy_ram_pkg::CONTROL_RESET;
            powerDown <= phy_ram_pkg::CONTROL_RESET[phy_ram_pkg::CTRL_POWER_DOWN_BIT];
        end else if (wrAccepted && regAddr == phy_ram_pkg::REG_BASIC_CONTROL) begin
            control   <= regWrData;
            powerDown <= regWrData[phy_ram_pkg::CTRL_POWER_DOWN_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            accessMode <= phy_ram_pkg::ACCESS_MODE_RESET;
        end else if (wrAccepted && regAddr == phy_ram_pkg::REG_EXPANDED_ACCESS_MODE) begin
            accessMode <= regWrData;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            execStart <= 1'b0;
            execAddr  <= 16'h0000;
        end else begin
            execStart <= wrAccepted && regAddr == phy_ram_pkg::REG_CODE_EXECUTE_START;
            if (wrAccepted && regAddr == phy_ram_pkg::REG_CODE_EXECUTE_START) begin
                execAddr <= regWrData;
            end
        end
    end

    // attention raised by start, cleared by a control read; start wins
    always_ff @(posedge clock) begin
        if (srst) begin
            codeAttention <= 1'b0;
        end else if (execStart) begin
            codeAttention <= 1'b1;
        end else if (regRead && regAddr == phy_ram_pkg::REG_BASIC_CONTROL) begin
            codeAttention <= 1'b0;
        end
    end

    // latched-low link bit; a loss beats the re-arm of a read
    always_ff @(posedge clock) begin
        if (srst) begin
            linkLatch <= 1'b0;
        end else if (!linkUp) begin
            linkLatch <= 1'b0;
        end else if (regRead && regAddr == phy_ram_pkg::REG_BASIC_LINK_STATE) begin
            linkLatch <= 1'b1;
        end
    end

    // Register read answers
    always_ff @(posedge clock) begin
        if (srst) begin
            regRdData  <= 16'h0000;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= 1'b0;
            if (dataReadNow) begin
                regRdData  <= {8'h00, readByte};
                regRdValid <= 1'b1;
            end else if (regRead && regAddr != phy_ram_pkg::REG_EXPANDED_RAM_DATA) begin
                regRdValid <= 1'b1;
                regRdData  <= 16'h0000;
                unique case (regAddr)
                    phy_ram_pkg::REG_BASIC_CONTROL: begin
                        regRdData <= control;
                    end
                    phy_ram_pkg::REG_BASIC_LINK_STATE: begin
                        regRdData[phy_ram_pkg::LINK_STATE_BIT] <= linkLatch;
                    end
                    phy_ram_pkg::REG_LIVE_LINK_SPEED_DUPLEX: begin
                        regRdData[phy_ram_pkg::LINK_STATE_BIT]  <= linkUp;
                        regRdData[phy_ram_pkg::LIVE_DUPLEX_BIT] <= fullDuplex;
                        regRdData[phy_ram_pkg::LIVE_SPEED_LSB +: 2] <= linkSpeed;
                    end
                    phy_ram_pkg::REG_EXPANDED_ACCESS_MODE: begin
                        regRdData <= accessMode;
                    end
                    phy_ram_pkg::REG_EXPANDED_RAM_POINTER: begin
                        regRdData <= pointer;
                    end
                    default: begin
                        regRdData <= 16'h0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            writeReady <= 1'b0;
        end else begin
            writeReady <= fifoInReady && !pushValid;
        end
    end

    // speed lights gated by good link
    always_ff @(posedge clock) begin
        if (srst) begin
            ledSpeed10   <= 1'b0;
            ledSpeed100  <= 1'b0;
            ledSpeed1000 <= 1'b0;
        end else begin
            ledSpeed10   <= linkUp && linkSpeed == phy_ram_pkg::SPEED_10;
            ledSpeed100  <= linkUp && linkSpeed == phy_ram_pkg::SPEED_100;
            ledSpeed1000 <= linkUp && linkSpeed == phy_ram_pkg::SPEED_1000;
        end
    end

endmodule

`default_nettype wire

// ---- hw/phy_ram_pkg.sv ----
package phy_ram_pkg;

    // Management register offsets
    localparam logic [4:0]  REG_BASIC_CONTROL          = 5'h00;
    localparam logic [4:0]  REG_BASIC_LINK_STATE       = 5'h01;
    localparam logic [4:0]  REG_LIVE_LINK_SPEED_DUPLEX = 5'h11;
    localparam logic [4:0]  REG_EXPANDED_ACCESS_MODE   = 5'h16;
    localparam logic [4:0]  REG_EXPANDED_RAM_DATA      = 5'h1D;
    localparam logic [4:0]  REG_EXPANDED_RAM_POINTER   = 5'h1E;
    localparam logic [4:0]  REG_CODE_EXECUTE_START     = 5'h1F;

    // Field positions
    localparam int          CTRL_POWER_DOWN_BIT = 11;
    localparam int          LINK_STATE_BIT      = 2;
    localparam int          LIVE_DUPLEX_BIT     = 1;
    localparam int          LIVE_SPEED_LSB      = 3;

    // Reset values
    localparam logic [15:0] CONTROL_RESET     = 16'h0000;
    localparam logic [15:0] ACCESS_MODE_RESET = 16'h0000;
    localparam logic [15:0] POINTER_RESET     = 16'h0000;

    // Access mode selections
    localparam logic [15:0] MODE_BYTE_ACCESS = 16'h000D;
    localparam logic [15:0] MODE_WORD_ACCESS = 16'h0006;

    // Expanded address map
    localparam logic [15:0] RAM_BASE_ADDR      = 16'h8000;
    localparam int          RAM_BYTES          = 14336;
    localparam int          RAM_INDEX_WIDTH    = 14;
    localparam logic [15:0] PAUSE_ADVERT_ADDR  = 16'h8084;
    localparam logic [7:0]  PAUSE_ADVERT_VALUE = 8'h01;
    localparam logic [15:0] CHECKSUM_CALC_ADDR = 16'h83FE;
    localparam logic [15:0] ROM_REV_HI_ADDR    = 16'hD002;
    localparam logic [15:0] ROM_REV_LO_ADDR    = 16'hD003;
    localparam logic [15:0] DOWNLOAD_START     = 16'h8400;

    // Resolved speed codes
    localparam logic [1:0]  SPEED_10   = 2'h0;
    localparam logic [1:0]  SPEED_100  = 2'h1;
    localparam logic [1:0]  SPEED_1000 = 2'h2;

    // Write buffer shape
    localparam int          WRITE_FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        ENTRY_POINTER = 2'h0,
        ENTRY_BYTE    = 2'h1,
        ENTRY_WORD    = 2'h2
    } entry_kind_e;

    typedef struct packed {
        entry_kind_e kind;
        logic [15:0] value;
    } write_entry_s;

    localparam int          WRITE_ENTRY_WIDTH = $bits(write_entry_s);

endpackage

// ---- hw/write_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module write_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;
    logic [PW:0]      next_count;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outValid = (count != '0);
    assign outData = store[rdPtr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            wrPtr   <= '0;
            rdPtr   <= '0;
            count   <= '0;
            inReady <= 1'b1;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count   <= next_count;
            // Registered full flag keeps the ready path short
            inReady <= (next_count != (PW+1)'(DEPTH));
        end
    end

endmodule

`default_nettype wire

// ---- verif/phy_ram_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module phy_ram_chk (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic [4:0]  regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic        writeReady,
    input wire logic [15:0] regRdData,
    input wire logic        regRdValid,
    input wire logic        linkUp,
    input wire logic [1:0]  linkSpeed,
    input wire logic        fullDuplex,
    input wire logic        execStart,
    input wire logic        codeAttention,
    input wire logic        ledSpeed10,
    input wire logic        ledSpeed100,
    input wire logic        ledSpeed1000
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);
    wire logic taken;
    assign taken = regWrite && writeReady;
    // Only buffered writes hold off the next one; pointer writes always enter the buffer
    property p_write_gap;
        taken && regAddr == 5'h1E |=> !writeReady;
    endproperty
    a_write_gap: assert property (p_write_gap) else $error("write taken twice in a row");
    property p_exec_start;
        taken && regAddr == 5'h1F |-> ##[1:40] execStart;
    endproperty
    a_exec_start: assert property (p_exec_start) else $error("no start pulse");
    property p_exec_pulse;
        execStart |=> !execStart && codeAttention;
    endproperty
    a_exec_pulse: assert property (p_exec_pulse) else $error("start pulse shape");
    property p_attn_clear;
        regRead && regAddr == 5'h00 && !execStart |-> ##[1:2] !codeAttention;
    endproperty
    a_attn_clear: assert property (p_attn_clear) else $error("attention not cleared");
    property p_live;
        regRead && regAddr == 5'h11 |=> regRdValid && regRdData[2] == $past(linkUp)
            && regRdData[4:3] == $past(linkSpeed) && regRdData[1] == $past(fullDuplex);
    endproperty
    a_live: assert property (p_live) else $error("live status wrong");
    property p_latch;
        regRead && regAddr == 5'h01 && !linkUp && !$past(linkUp) && !$past(srst)
            |=> regRdValid && !regRdData[2];
    endproperty
    a_latch: assert property (p_latch) else $error("link loss not latched");
    property p_leds;
        !$past(srst) |-> ledSpeed10 == ($past(linkUp) && $past(linkSpeed) == 2'h0)
            && ledSpeed100 == ($past(linkUp) && $past(linkSpeed) == 2'h1)
            && ledSpeed1000 == ($past(linkUp) && $past(linkSpeed) == 2'h2);
    endproperty
    a_leds: assert property (p_leds) else $error("speed indicator wrong");
    property p_read_answer;
        regRead && regAddr != 5'h1D |=> regRdValid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
endmodule
bind phy_expanded_ram_access phy_ram_chk chk_u (.*);
`default_nettype wire

// ---- verif/station_manager.sv ----
`timescale 1ns/10ps
`default_nettype none
module station_manager #(
    parameter int QUIET_CYCLES = 128000
) (
    input  wire logic        clock,
    input  wire logic        writeReady,
    input  wire logic [15:0] regRdData,
    input  wire logic        regRdValid,
    output logic [4:0]       regAddr,
    output logic [15:0]      regWrData,
    output logic             regWrite,
    output logic             regRead
);
    initial begin
        regAddr = 5'h00;
        regWrData = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // Request held until an edge samples writeReady high
    task automatic writeReg(input logic [4:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (writeReady !== 1'b1 && n < 60);
        regWrite <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic readReg(input logic [4:0] a, output logic [15:0] d);
        int n;
        n = 0;
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (regRdValid !== 1'b1 && n < 100);
        d = regRdData;
    endtask
    task automatic quiet;
        repeat (QUIET_CYCLES) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ---- verif/phy_expanded_ram_access_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module phy_expanded_ram_access_test;
    localparam logic [7:0] REV_HI = 8'h6C;  // Arbitrary value
    localparam logic [7:0] REV_LO = 8'hC6;  // Arbitrary value
    localparam logic [4:0] PTR = phy_ram_pkg::REG_EXPANDED_RAM_POINTER;
    localparam logic [4:0] DATA = phy_ram_pkg::REG_EXPANDED_RAM_DATA;
    localparam logic [4:0] MODE = phy_ram_pkg::REG_EXPANDED_ACCESS_MODE;
    localparam logic [15:0] BYTE = phy_ram_pkg::MODE_BYTE_ACCESS;
    localparam logic [15:0] DL = phy_ram_pkg::DOWNLOAD_START;
    logic clock, srst, regWrite, regRead, writeReady, regRdValid, linkUp, fullDuplex;
    logic eepromByteValid, eepromLoadDone, powerDown, asymPauseAdvert, execStart;
    logic codeAttention, ledSpeed10, ledSpeed100, ledSpeed1000;
    logic [4:0] regAddr;
    logic [1:0] linkSpeed;
    logic [7:0] eepromByte;
    logic [15:0] regWrData, regRdData, execAddr, rd;
    int failures;
    int checks_done;
    phy_expanded_ram_access #(.ROM_REV_HI(REV_HI), .ROM_REV_LO(REV_LO)) dut_u (.*);
    station_manager #(.QUIET_CYCLES(64)) mgr_u (.*);
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        mgr_u.writeReg(a, d);
    endtask
    task automatic rdChk(input string what, input logic [4:0] a, input logic [15:0] exp);
        mgr_u.readReg(a, rd);
        check(what, exp, rd);
    endtask
    task automatic readByte(input logic [15:0] addr, input logic [7:0] exp);
        wr(PTR, addr);
        rdChk("ram byte", DATA, {8'h00, exp});
    endtask
    // Lets the write buffer drain before side effects are looked at
    task automatic settle;
        repeat (40) @(posedge clock);
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        summarize;
    end
    initial begin
        {srst, linkUp, linkSpeed, fullDuplex} = 5'h10;
        {eepromByte, eepromByteValid, eepromLoadDone} = 10'h000;
        failures = 0;
        checks_done = 0;
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        rdChk("control", 5'h00, phy_ram_pkg::CONTROL_RESET);
        rdChk("mode", MODE, phy_ram_pkg::ACCESS_MODE_RESET);
        rdChk("pointer", PTR, phy_ram_pkg::POINTER_RESET);
        rdChk("unmapped", 5'h05, 16'h0000);
        $display("test reset done");
        wr(5'h00, 16'h0800);
        settle;
        check("powerDown", 16'h0001, {15'h0, powerDown});
        wr(MODE, BYTE);
        wr(PTR, phy_ram_pkg::PAUSE_ADVERT_ADDR);
        wr(DATA, 16'hAB01);
        settle;
        check("pause", 16'h0001, {15'h0, asymPauseAdvert});
        rdChk("pointer", PTR, phy_ram_pkg::PAUSE_ADVERT_ADDR + 16'h1);
        readByte(phy_ram_pkg::PAUSE_ADVERT_ADDR, 8'h01);
        rdChk("pointer", PTR, phy_ram_pkg::PAUSE_ADVERT_ADDR + 16'h1);
        wr(PTR, phy_ram_pkg::PAUSE_ADVERT_ADDR);
        wr(DATA, 16'h0000);
        settle;
        check("pause", 16'h0000, {15'h0, asymPauseAdvert});
        $display("test byte mode done");
        wr(MODE, phy_ram_pkg::MODE_WORD_ACCESS);
        // image loaded from the start address
        wr(PTR, DL);
        for (int i = 0; i < 12; i++) begin
            wr(DATA, {8'hC0 + 8'(i), 8'h50 + 8'(i)});
        end
        settle;
        rdChk("pointer", PTR, DL + 16'd24);
        wr(MODE, BYTE);
        wr(PTR, DL);
        for (int i = 0; i < 24; i++) begin
            rdChk("image", DATA, {8'h00, (i[0] ? 8'hC0 : 8'h50) + 8'(i / 2)});
        end
        $display("test word mode done");
        wr(PTR, 16'hB7FF);
        wr(DATA, 16'h0077);
        wr(DATA, 16'h0066);
        readByte(16'hB7FF, 8'h77);
        readByte(16'hB800, 8'h00);
        wr(MODE, 16'h0003);
        wr(PTR, DL);
        wr(DATA, 16'h00EE);
        settle;
        rdChk("pointer", PTR, DL);
        wr(MODE, BYTE);
        readByte(DL, 8'h50);
        $display("test bounds done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            eepromByte <= 8'h70 + 8'(i);
            eepromByteValid <= 1'b1;
        end
        @(posedge clock);
        eepromByteValid <= 1'b0;
        eepromLoadDone <= 1'b1;
        @(posedge clock);
        eepromLoadDone <= 1'b0;
        readByte(phy_ram_pkg::CHECKSUM_CALC_ADDR, 8'h53);
        wr(PTR, 16'h83FF);
        wr(DATA, 16'h005C);
        readByte(16'h83FF, 8'h5C);
        readByte(phy_ram_pkg::ROM_REV_HI_ADDR, REV_HI);
        readByte(phy_ram_pkg::ROM_REV_LO_ADDR, REV_LO);
        $display("test fixed places done");
        wr(phy_ram_pkg::REG_CODE_EXECUTE_START, DL);
        repeat (50) begin
            @(posedge clock);
            if (execStart === 1'b1) break;
        end
        check("execAddr", DL, execAddr);
        mgr_u.quiet;
        check("attention", 16'h0001, {15'h0, codeAttention});
        rdChk("control", 5'h00, 16'h0800);
        repeat (2) @(posedge clock);
        check("attention", 16'h0000, {15'h0, codeAttention});
        wr(5'h00, 16'h0000);
        settle;
        check("powerDown", 16'h0000, {15'h0, powerDown});
        $display("test start done");
        for (int s = 0; s < 3; s++) begin
            @(posedge clock);
            linkUp <= 1'b1;
            linkSpeed <= 2'(s);
            fullDuplex <= s[0];
            repeat (3) @(posedge clock);
            mgr_u.readReg(phy_ram_pkg::REG_LIVE_LINK_SPEED_DUPLEX, rd);
            check("live", {11'h0, 2'(s), 1'b1, s[0], 1'b0}, rd & 16'h001E);
            check("leds", 16'(1 << s), {13'h0, ledSpeed1000, ledSpeed100, ledSpeed10});
        end
        @(posedge clock);
        linkUp <= 1'b0;
        repeat (3) @(posedge clock);
        check("leds", 16'h0000, {13'h0, ledSpeed1000, ledSpeed100, ledSpeed10});
        rdChk("link latch", phy_ram_pkg::REG_BASIC_LINK_STATE, 16'h0000);
        linkUp <= 1'b1;
        mgr_u.readReg(phy_ram_pkg::REG_BASIC_LINK_STATE, rd);
        check("link latch", 16'h0000, {15'h0, rd[2]});
        mgr_u.readReg(phy_ram_pkg::REG_BASIC_LINK_STATE, rd);
        check("link live", 16'h0001, {15'h0, rd[2]});
        $display("test link done");
        summarize;
    end
endmodule
`default_nettype wire
